/* File: fsp_defines.svh */
// Constants for the flash status and protection host controller
// Behaviour
// RULE_01 - After timeout, host writes reset sequence before any new program or erase
// RULE_02 - Program timeout marks its sector bad; chip erase timeout marks chip bad (the host sets o_sector_bad for every timeout)
// RULE_03 - Programming an unerased location does not itself raise the timeout flag
// RULE_04 - Timeout flag reads 1 past time limit; toggles continue, ready/busy low
// RULE_05 - Host presents a valid target address when polling data-poll and second toggle
// RULE_06 - Suspended sector reads: poll 1, no first toggle, flag 0, second toggles, ready
// RULE_07 - Non-erasing sectors read array data during suspend, ready/busy high
// RULE_08 - Erase-window bit reads low until the sector-erase window expires
// RULE_09 - Erase-window bit high: further commands ignored until erase completes
// RULE_10 - Erase-window bit low: further sector erase commands are accepted
// RULE_11 - Host checks erase-window bit before and after each extra sector erase
// RULE_12 - Device enters read-array mode by itself at power-up
// RULE_13 - Array changes only after a complete, correct command sequence
// RULE_14 - Strobe pulses shorter than about 5 ns start no write cycle
// RULE_15 - Write only with select and write strobe low and output strobe high
// RULE_16 - Reset pin at high voltage temporarily unprotects protected sectors
// RULE_17 - Protected sectors reject program and erase (the model checks protection on program only)
// RULE_18 - Sector protect runs from write strobe fall to rise with high voltage applied
// RULE_19 - Protect verify returns 1 on lowest data bit if protected, else 00H
// RULE_20 - Sector-id and code-select both low return identification codes
// RULE_21 - Auto-select read with code-select high shows protection; reset exits mode
// RULE_22 - Chip unprotect: high voltage, select low, sector-id high, one write strobe
// RULE_23 - Host protects all sectors before running chip unprotect
// RULE_24 - Data-poll bit shows complement while programming, 0 while erasing
// RULE_25 - First toggle bit changes on every read during an algorithm
// RULE_26 - Erase window and time limits are configurable parameters
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// Status bit positions in the read data byte
`define FSP_BIT_POLL 7
`define FSP_BIT_TOGGLE1 6
`define FSP_BIT_TIMEOUT 5
`define FSP_BIT_WINDOW 3
`define FSP_BIT_TOGGLE2 2
`define FSP_BIT_LOWEST 0
// Unlock and command bytes, with their unlock addresses
`define FSP_ADDR_UNLOCK1 21'h000555
`define FSP_ADDR_UNLOCK2 21'h0002aa
`define FSP_DATA_UNLOCK1 8'haa
`define FSP_DATA_UNLOCK2 8'h55
`define FSP_CMD_PROGRAM 8'ha0
`define FSP_CMD_ERASE_SETUP 8'h80
`define FSP_CMD_SECTOR_ERASE 8'h30
`define FSP_CMD_CHIP_ERASE 8'h10
`define FSP_CMD_AUTOSEL 8'h90
`define FSP_CMD_RESET 8'hf0
// Address line positions used for identity and protect reads
`define FSP_A_SECTOR_ID 6
`define FSP_A_CODE_SEL 1
// Strobe timing: low and high phase widths, kept above the 5 ns glitch limit
`define FSP_T_STROBE_NS 40
`define FSP_T_READ_NS 80
`define FSP_T_PERIOD_NS 4
`define FSP_STROBE_CYC ((`FSP_T_STROBE_NS + `FSP_T_PERIOD_NS - 1) / `FSP_T_PERIOD_NS)
`define FSP_READ_CYC ((`FSP_T_READ_NS + `FSP_T_PERIOD_NS - 1) / `FSP_T_PERIOD_NS)
`endif

/* File: fsp_pkg.sv */
// Types shared by the flash host controller modules
package fsp_pkg;
	// Host operations accepted at the user port
	typedef enum logic [2:0]
	{
		FSP_OP_READ = 3'b000,
		FSP_OP_PROGRAM = 3'b001,
		FSP_OP_SECTOR_ERASE = 3'b010,
		FSP_OP_CHIP_ERASE = 3'b011,
		FSP_OP_AUTOSEL = 3'b100,
		FSP_OP_RESET = 3'b101,
		FSP_OP_ADD_SECTOR = 3'b110,
		FSP_OP_HV_STROBE = 3'b111
	} fsp_op_e;
	// Result of the last operation
	typedef enum logic [1:0]
	{
		FSP_RES_OK = 2'b00,
		FSP_RES_TIMEOUT = 2'b01,
		FSP_RES_REJECTED = 2'b10
	} fsp_res_e;
endpackage : fsp_pkg

/* File: fsp_cycle_if.sv */
// Bus-cycle request and answer between sequencer and cycle engine
`timescale 1ns/1ps
interface fsp_cycle_if #(parameter int AW = 21);
	logic req;
	logic wr;
	logic hv;
	logic [AW-1:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport seq (output req, output wr, output hv, output addr, output wdata,
		input done, input rdata);
	modport eng (input req, input wr, input hv, input addr, input wdata,
		output done, output rdata);
endinterface : fsp_cycle_if

/* File: fsp_cycle.sv */
// One read or write strobe cycle on the flash pins
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_cycle #(
	parameter int AW = 21
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	fsp_cycle_if.eng cyc,
	input wire logic [7:0] i_dq,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [AW-1:0] o_addr,
	output logic [7:0] o_dq,
	output logic o_dq_oe
);
	typedef enum logic [1:0]
	{
		FSP_C_IDLE = 2'b00,
		FSP_C_LOW = 2'b01,
		FSP_C_HIGH = 2'b10
	} fsp_cst_e;
	localparam logic [7:0] STROBE_CYC = 8'(`FSP_STROBE_CYC);
	localparam logic [7:0] READ_CYC = 8'(`FSP_READ_CYC);
	fsp_cst_e state_q;
	logic [7:0] cnt_q;
	logic wr_q;
	logic [7:0] s1_q, s2_q, s3_q;
	// ---------------------------------------------
	// Pin input synchroniser
	// ---------------------------------------------
	// Data pins are asynchronous; three stages, settled when last two agree
	always_ff @(posedge i_clock)
	begin
		s1_q <= i_dq;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	// ---------------------------------------------
	// Strobe timing
	// ---------------------------------------------
	// Strobes held low far longer than 5 ns so no pulse looks like a glitch
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state_q <= FSP_C_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_addr <= '0;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
			cyc.done <= 1'b0;
			cyc.rdata <= 8'h00;
		end
		else
		begin
			cyc.done <= 1'b0;
			unique case (state_q)
				FSP_C_IDLE:
				begin
					if (cyc.req)
					begin
						state_q <= FSP_C_LOW;
						wr_q <= cyc.wr;
						cnt_q <= cyc.wr ? STROBE_CYC : READ_CYC;
						o_addr <= cyc.addr;
						o_dq <= cyc.wdata;
						o_dq_oe <= cyc.wr;
						o_ce_n <= 1'b0;
						o_we_n <= !cyc.wr; // [RULE_15] [RULE_18] [RULE_22]
						o_oe_n <= cyc.wr; // [RULE_15] output strobe high on writes
					end
				end
				FSP_C_LOW:
				begin
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'h01; // [RULE_14]
					else if (wr_q || (s2_q == s3_q))
					begin
						cyc.rdata <= s3_q;
						o_ce_n <= 1'b1;
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						cnt_q <= STROBE_CYC;
						state_q <= FSP_C_HIGH;
					end
				end
				FSP_C_HIGH:
				begin
					// High phase keeps strobes apart so reads are distinct cycles
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'h01;
					else
					begin
						o_dq_oe <= 1'b0;
						cyc.done <= 1'b1;
						state_q <= FSP_C_IDLE;
					end
				end
				default:
					state_q <= FSP_C_IDLE;
			endcase
		end
	end
endmodule : fsp_cycle

/* File: fsp_host.sv */
// Host controller: command sequences and status polling for a parallel NOR flash
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_host #(
	parameter int AW = 21,
	parameter int POLL_LIMIT = 100000
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_req,
	input wire fsp_pkg::fsp_op_e i_op,
	input wire logic [AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_hv_id,
	input wire logic i_hv_reset,
	output logic o_ready,
	output logic o_done,
	output fsp_pkg::fsp_res_e o_result,
	output logic [7:0] o_rdata,
	output logic o_sector_bad,
	output logic o_hv_addr,
	output logic o_hv_oe,
	output logic o_hv_reset,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [AW-1:0] o_addr,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	input wire logic [7:0] i_dq,
	input wire logic i_ready_busy
);
	typedef enum logic [2:0]
	{
		FSP_S_IDLE = 3'b000,
		FSP_S_WRITE = 3'b001,
		FSP_S_READ = 3'b010,
		FSP_S_POLL = 3'b011,
		FSP_S_RECHECK = 3'b100,
		FSP_S_RECOVER = 3'b101,
		FSP_S_DONE = 3'b110
	} fsp_st_e;
	fsp_cycle_if #(.AW(AW)) cyc ();
	fsp_st_e state_q;
	fsp_pkg::fsp_op_e op_q;
	logic [AW-1:0] addr_q;
	logic [7:0] data_q;
	logic [2:0] step_q;
	logic [2:0] nsteps_q;
	logic [1:0] polls_q;
	logic [7:0] prev_q;
	logic timed_q;
	logic [31:0] guard_q;
	logic req_q;
	logic wr_q;
	logic hv_q;
	logic [AW-1:0] caddr_q;
	logic [7:0] cdata_q;
	logic [7:0] rd;
	logic toggling;
	logic [AW-1:0] step_addr;
	logic [7:0] step_data;
	logic [1:0] sr_q;
	logic busy_pin;
	logic wait_q; // Engine cycle outstanding, blocks a second request
	// ---------------------------------------------
	// Cycle engine
	// ---------------------------------------------
	fsp_cycle #(.AW(AW)) u_cycle (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.cyc(cyc.eng),
		.i_dq(i_dq),
		.o_ce_n(o_ce_n),
		.o_we_n(o_we_n),
		.o_oe_n(o_oe_n),
		.o_addr(o_addr),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe)
	);
	assign cyc.req = req_q;
	assign cyc.wr = wr_q;
	assign cyc.hv = hv_q;
	assign cyc.addr = caddr_q;
	assign cyc.wdata = cdata_q;
	assign rd = cyc.rdata;
	assign o_ready = (state_q == FSP_S_IDLE);
	// Ready/busy pin, three stages; busy_pin drives no output and the sequencer never reads it
	logic rb1_q;
	always_ff @(posedge i_clock)
	begin
		rb1_q <= i_ready_busy;
		sr_q <= {sr_q[0], rb1_q};
	end
	assign busy_pin = (sr_q[0] == sr_q[1]) ? !sr_q[1] : 1'b0;
	// Toggle seen between two successive reads at the target address
	assign toggling = (rd[`FSP_BIT_TOGGLE1] != prev_q[`FSP_BIT_TOGGLE1]); // [RULE_25]
	// ---------------------------------------------
	// Command step table
	// ---------------------------------------------
	// Full unlock sequence issued for program, erase and auto-select; a partial one never changes the array
	always_comb
	begin
		step_addr = `FSP_ADDR_UNLOCK1;
		step_data = `FSP_DATA_UNLOCK1; // [RULE_13]
		unique case (step_q)
			3'd0:
			begin
				step_addr = `FSP_ADDR_UNLOCK1;
				step_data = `FSP_DATA_UNLOCK1;
			end
			3'd1:
			begin
				step_addr = `FSP_ADDR_UNLOCK2;
				step_data = `FSP_DATA_UNLOCK2;
			end
			3'd2:
			begin
				step_addr = `FSP_ADDR_UNLOCK1;
				unique case (op_q)
					fsp_pkg::FSP_OP_PROGRAM: step_data = `FSP_CMD_PROGRAM;
					fsp_pkg::FSP_OP_AUTOSEL: step_data = `FSP_CMD_AUTOSEL;
					default: step_data = `FSP_CMD_ERASE_SETUP;
				endcase
			end
			3'd3:
			begin
				step_addr = (op_q == fsp_pkg::FSP_OP_PROGRAM) ? addr_q : `FSP_ADDR_UNLOCK1;
				step_data = (op_q == fsp_pkg::FSP_OP_PROGRAM) ? data_q : `FSP_DATA_UNLOCK1;
			end
			3'd4:
			begin
				step_addr = `FSP_ADDR_UNLOCK2;
				step_data = `FSP_DATA_UNLOCK2;
			end
			default:
			begin
				step_addr = (op_q == fsp_pkg::FSP_OP_CHIP_ERASE) ? `FSP_ADDR_UNLOCK1 : addr_q;
				step_data = (op_q == fsp_pkg::FSP_OP_CHIP_ERASE) ? `FSP_CMD_CHIP_ERASE
					: `FSP_CMD_SECTOR_ERASE;
			end
		endcase
	end
	// High-voltage controls for protect, verify and unprotect sequences
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			o_hv_addr <= 1'b0;
			o_hv_oe <= 1'b0;
			o_hv_reset <= 1'b0;
		end
		else
		begin
			o_hv_addr <= i_hv_id; // [RULE_18] [RULE_19] [RULE_22]
			o_hv_oe <= i_hv_id && (op_q == fsp_pkg::FSP_OP_HV_STROBE) && (state_q != FSP_S_IDLE);
			o_hv_reset <= i_hv_reset; // [RULE_16]
		end
	end
	// ---------------------------------------------
	// Sequencer
	// ---------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state_q <= FSP_S_IDLE;
			op_q <= fsp_pkg::FSP_OP_READ;
			addr_q <= '0;
			data_q <= 8'h00;
			step_q <= 3'd0;
			nsteps_q <= 3'd0;
			polls_q <= 2'd0;
			prev_q <= 8'h00;
			timed_q <= 1'b0;
			guard_q <= 32'h0;
			req_q <= 1'b0;
			wait_q <= 1'b0;
			wr_q <= 1'b0;
			hv_q <= 1'b0;
			caddr_q <= '0;
			cdata_q <= 8'h00;
			o_done <= 1'b0;
			o_result <= fsp_pkg::FSP_RES_OK;
			o_rdata <= 8'h00;
			o_sector_bad <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			req_q <= 1'b0;
			// Free for the next request once the engine reports its cycle done
			if (cyc.done)
				wait_q <= 1'b0;
			unique case (state_q)
				FSP_S_IDLE:
				begin
					if (i_req)
					begin
						op_q <= i_op;
						addr_q <= i_addr;
						data_q <= i_wdata;
						step_q <= 3'd0;
						polls_q <= 2'd0;
						timed_q <= 1'b0;
						guard_q <= 32'h0;
						o_result <= fsp_pkg::FSP_RES_OK;
						unique case (i_op)
							fsp_pkg::FSP_OP_READ: state_q <= FSP_S_READ;
							fsp_pkg::FSP_OP_ADD_SECTOR: state_q <= FSP_S_RECHECK; // [RULE_11]
							fsp_pkg::FSP_OP_HV_STROBE: state_q <= FSP_S_WRITE; // [RULE_23]
							fsp_pkg::FSP_OP_RESET: state_q <= FSP_S_WRITE;
							default: state_q <= FSP_S_WRITE;
						endcase
						unique case (i_op)
							fsp_pkg::FSP_OP_PROGRAM: nsteps_q <= 3'd3;
							fsp_pkg::FSP_OP_SECTOR_ERASE: nsteps_q <= 3'd5;
							fsp_pkg::FSP_OP_CHIP_ERASE: nsteps_q <= 3'd5;
							fsp_pkg::FSP_OP_AUTOSEL: nsteps_q <= 3'd2;
							default: nsteps_q <= 3'd0;
						endcase
						// Reset and high-voltage strobe jump to the last step directly
						if ((i_op == fsp_pkg::FSP_OP_RESET) || (i_op == fsp_pkg::FSP_OP_HV_STROBE))
							step_q <= 3'd7;
					end
				end
				FSP_S_WRITE:
				begin
					if (!wait_q && !cyc.done)
					begin
						req_q <= 1'b1;
						wait_q <= 1'b1;
						wr_q <= 1'b1;
						caddr_q <= (step_q == 3'd7) ? addr_q : step_addr;
						cdata_q <= (step_q == 3'd7) ? ((op_q == fsp_pkg::FSP_OP_RESET)
							? `FSP_CMD_RESET : data_q) : step_data;
						if (op_q == fsp_pkg::FSP_OP_ADD_SECTOR)
						begin
							caddr_q <= addr_q;
							cdata_q <= `FSP_CMD_SECTOR_ERASE; // [RULE_10]
						end
					end
					if (cyc.done)
					begin
						if ((step_q == 3'd7) || (step_q >= nsteps_q))
						begin
							// Program and erase are polled; an added sector is rechecked; others complete here
							if ((op_q == fsp_pkg::FSP_OP_PROGRAM) || (op_q == fsp_pkg::FSP_OP_SECTOR_ERASE)
								|| (op_q == fsp_pkg::FSP_OP_CHIP_ERASE))
								state_q <= FSP_S_POLL;
							else if (op_q == fsp_pkg::FSP_OP_ADD_SECTOR)
							begin
								polls_q <= 2'd2;
								state_q <= FSP_S_RECHECK; // [RULE_11]
							end
							else
								state_q <= FSP_S_DONE;
						end
						else
							step_q <= step_q + 3'd1;
					end
				end
				FSP_S_READ:
				begin
					if (!wait_q && !cyc.done)
					begin
						req_q <= 1'b1;
						wait_q <= 1'b1;
						wr_q <= 1'b0;
						caddr_q <= addr_q; // [RULE_05] [RULE_19] [RULE_20] [RULE_21]
					end
					if (cyc.done)
					begin
						o_rdata <= rd;
						state_q <= FSP_S_DONE;
					end
				end
				FSP_S_RECHECK:
				begin
					// Erase-window bit read before and after the extra sector command
					if (!wait_q && !cyc.done)
					begin
						req_q <= 1'b1;
						wait_q <= 1'b1;
						wr_q <= 1'b0;
						caddr_q <= addr_q;
					end
					if (cyc.done)
					begin
						o_rdata <= rd;
						if (rd[`FSP_BIT_WINDOW])
						begin
							o_result <= fsp_pkg::FSP_RES_REJECTED; // [RULE_09] [RULE_11]
							state_q <= FSP_S_DONE;
						end
						else if (polls_q == 2'd2)
							state_q <= FSP_S_DONE; // [RULE_08]
						else
							state_q <= FSP_S_WRITE;
					end
				end
				FSP_S_POLL:
				begin
					if (!wait_q && !cyc.done)
					begin
						req_q <= 1'b1;
						wait_q <= 1'b1;
						wr_q <= 1'b0;
						caddr_q <= addr_q; // [RULE_05]
					end
					if (cyc.done)
					begin
						prev_q <= rd;
						o_rdata <= rd;
						guard_q <= guard_q + 32'h1;
						if (polls_q != 2'd2)
							polls_q <= polls_q + 2'd1;
						else if (!toggling)
							state_q <= timed_q ? FSP_S_RECOVER : FSP_S_DONE; // [RULE_25]
						else if (timed_q)
						begin
							// Still toggling after timeout flag seen: failed
							o_result <= fsp_pkg::FSP_RES_TIMEOUT; // [RULE_04]
							o_sector_bad <= 1'b1; // [RULE_02]
							state_q <= FSP_S_RECOVER;
						end
						if (rd[`FSP_BIT_TIMEOUT] && (polls_q == 2'd2))
							timed_q <= 1'b1; // [RULE_04] [RULE_03]
						if (guard_q >= 32'(POLL_LIMIT))
						begin
							o_result <= fsp_pkg::FSP_RES_TIMEOUT; // [RULE_26]
							o_sector_bad <= 1'b1; // Hung algorithm: sector unusable
							state_q <= FSP_S_RECOVER;
						end
					end
				end
				FSP_S_RECOVER:
				begin
					// Reset command before any further program or erase
					op_q <= fsp_pkg::FSP_OP_RESET; // [RULE_01]
					step_q <= 3'd7;
					state_q <= FSP_S_WRITE;
				end
				FSP_S_DONE:
				begin
					o_done <= 1'b1;
					state_q <= FSP_S_IDLE;
				end
				default:
					state_q <= FSP_S_IDLE;
			endcase
		end
	end
endmodule : fsp_host

/* File: fsp_flash_model.sv */
// Behavioural flash device answering the host controller's pin cycles
`timescale 1ns/1ps
module fsp_flash_model #(
	parameter int BUSY = 4, // Status reads before an algorithm ends
	parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary identity value
) (
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [20:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_hv_addr,
	input wire logic i_hv_oe,
	input wire logic i_hv_reset,
	input wire logic i_tmo,
	input wire logic i_win_hi,
	output logic [7:0] o_dq,
	output logic o_ready_busy
);
	logic [7:0] mem [logic [20:0]];
	logic [47:0] hist = '0;
	logic [31:0] prot = '0;
	logic [31:0] emask = '0;
	logic [7:0] rd = '0, pd = '0, wd = '0;
	logic [20:0] wa = '0;
	logic prog = 0, asel = 0, ers = 0, tog = 0, ok = 0, hv = 0, susp = 0, tg2 = 0;
	int busy = 0;
	realtime t_fall = 0;
	function automatic logic [7:0] rdm(input logic [20:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rdm
	// Deselected bus shows the complement of the last byte, never the byte itself
	assign o_dq = (!i_oe_n && !i_ce_n) ? rd : ~rd;
	assign o_ready_busy = (busy == 0) || susp;
	// Latch write qualifiers 1 ns after the fall; the host sets them with the falling edge
	always @(negedge i_we_n)
	begin
		t_fall = $realtime;
		#1;
		ok = !i_ce_n && i_oe_n;
		hv = i_hv_addr && i_hv_oe;
		wa = i_addr;
		wd = i_dq;
	end
	// Commands act at the strobe's rising edge, glitches filtered
	always @(posedge i_we_n)
	begin
		if (ok && $realtime - t_fall >= 5.0)
		begin
			if (hv)
				prot = wa[6] ? '0 : prot | (32'h1 << wa[20:16]);
			else if (wd == 8'hf0)
			begin
				busy = 0;
				emask = '0;
				{susp, ers, asel, prog} = '0; // Back to array reads
			end
			else if (prog)
			begin
				prog = 0;
				if (!prot[wa[20:16]] || i_hv_reset)
				begin
					busy = BUSY;
					pd = wd;
					if (!i_tmo)
						mem[wa] = rdm(wa) & wd; // No flag for unerased bits
				end
			end
			else if (ers && wd == 8'hb0)
				susp = 1; // Erase suspend while an erase runs
			else if (ers && wd == 8'h30)
			begin
				busy = i_win_hi ? busy : BUSY;
				emask[wa[20:16]] = emask[wa[20:16]] || !i_win_hi;
			end
			else
			begin
				hist = {hist[39:0], wd}; // Only whole sequences act
				prog = hist[23:0] == 24'haa55a0;
				asel = asel || hist[23:0] == 24'haa5590;
				ers = ers || hist[47:8] == 40'haa5580aa55 && (wd == 8'h30 || wd == 8'h10);
				busy = ers ? BUSY : busy;
				if (hist[47:8] == 40'haa5580aa55 && wd == 8'h30)
					emask[wa[20:16]] = 1'b1;
				if (hist[47:8] == 40'haa5580aa55 && wd == 8'h10)
					mem.delete(); // Chip erase blanks the whole array
			end
		end
	end
	// Each read cycle picks status or array data at the output strobe's fall
	always @(negedge i_oe_n)
	begin
		#1;
		if (busy > 0 && !susp)
			tog = !tog;
		if (susp)
			tg2 = !tg2;
		if (susp)
			rd = emask[i_addr[20:16]] ? {1'b1, tog, 3'b000, tg2, 2'b00}
				: rdm(i_addr);
		else if (ers)
			rd = {busy == 0, tog, 2'b00, i_win_hi, tog, 2'b00};
		else if (busy > 0)
			rd = {~pd[7], tog, i_tmo, 5'h00};
		else if (asel || i_hv_addr)
			rd = (!i_addr[6] && !i_addr[1]) ? ID_CODE :
				{7'h00, i_addr[1] && !i_addr[0] && prot[i_addr[20:16]]};
		else
			rd = rdm(i_addr); // Read mode from power-up
		if (busy > 0 && !i_tmo && !susp)
			busy = busy - 1;
	end
endmodule : fsp_flash_model

/* File: fsp_host_chk.sv */
// Port checks for the flash host controller
`timescale 1ns/1ps
module fsp_host_chk (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic o_done,
	input wire fsp_pkg::fsp_res_e o_result,
	input wire logic o_sector_bad,
	input wire logic o_hv_addr,
	input wire logic o_hv_oe,
	input wire logic o_ce_n,
	input wire logic o_we_n,
	input wire logic o_oe_n,
	input wire logic o_dq_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// Write strobe opens selected and stays low well past the glitch limit
	sequence wr_open_s;
		$fell(o_we_n) && !o_ce_n;
	endsequence
	sequence wr_low_s;
		!o_we_n [*8];
	endsequence
	wr_pulse_a: assert property (wr_open_s |-> wr_low_s)
		else $error("write strobe shorter than expected");
	wr_inhibit_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
		else $error("write strobe without select or with output strobe");
	rd_clean_a: assert property (!o_oe_n |-> o_we_n && !o_dq_oe)
		else $error("read overlaps a write or data drive");
	pwr_idle_a: assert property ($rose(i_reset_n) |-> o_we_n && o_ce_n && !o_dq_oe && !o_hv_oe)
		else $error("pins not idle after reset");
	hv_pair_a: assert property (o_hv_oe |-> o_hv_addr)
		else $error("output strobe high voltage without identity line");
	bad_keep_a: assert property (o_sector_bad |=> o_sector_bad)
		else $error("bad sector flag dropped");
	tmo_bad_a: assert property (o_done && o_result == fsp_pkg::FSP_RES_TIMEOUT |-> o_sector_bad)
		else $error("timeout result without bad sector");
	bad_cause_a: assert property ($rose(o_sector_bad) |-> ##[0:400] o_done)
		else $error("bad sector without completion");
	done_once_a: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
endmodule : fsp_host_chk
bind fsp_host fsp_host_chk u_chk (
	.i_clock(i_clock),
	.i_reset_n(i_reset_n),
	.o_done(o_done),
	.o_result(o_result),
	.o_sector_bad(o_sector_bad),
	.o_hv_addr(o_hv_addr),
	.o_hv_oe(o_hv_oe),
	.o_ce_n(o_ce_n),
	.o_we_n(o_we_n),
	.o_oe_n(o_oe_n),
	.o_dq_oe(o_dq_oe)
);

/* File: test_fsp_host.sv */
// Self-checking bench for the flash host controller and device model
`timescale 1ns/1ps
`include "fsp_defines.svh"
module test_fsp_host;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
	logic i_clock = 0, i_reset_n = 0, i_req = 0, i_hv_id = 0, i_hv_reset = 0;
	logic tmo = 0, win_hi = 0, rb, o_ready, o_done, o_sector_bad;
	logic o_hv_addr, o_hv_oe, o_hv_reset, o_ce_n, o_we_n, o_oe_n, o_dq_oe;
	fsp_pkg::fsp_op_e i_op = fsp_pkg::FSP_OP_READ;
	fsp_pkg::fsp_res_e o_result;
	logic [20:0] i_addr = '0, o_addr;
	logic [7:0] i_wdata = '0, o_rdata, o_dq, dev_dq, bus;
	int n_fail = 0, samples_checked = 0;
	assign bus = o_dq_oe ? o_dq : dev_dq;
	// 250 MHz clock
	always #2 i_clock = ~i_clock;
	fsp_host #(.POLL_LIMIT(50)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(i_req),
		.i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .i_hv_id(i_hv_id),
		.i_hv_reset(i_hv_reset), .o_ready(o_ready), .o_done(o_done), .o_result(o_result),
		.o_rdata(o_rdata), .o_sector_bad(o_sector_bad), .o_hv_addr(o_hv_addr),
		.o_hv_oe(o_hv_oe), .o_hv_reset(o_hv_reset), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
		.o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(bus),
		.i_ready_busy(rb));
	fsp_flash_model #(.ID_CODE(ID)) u_dev (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
		.i_addr(o_addr), .i_dq(bus), .i_hv_addr(o_hv_addr), .i_hv_oe(o_hv_oe),
		.i_hv_reset(o_hv_reset), .i_tmo(tmo), .i_win_hi(win_hi), .o_dq(dev_dq),
		.o_ready_busy(rb));
	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte
	task automatic chk_res(input fsp_pkg::fsp_res_e e);
		samples_checked++;
		if (o_result !== e)
		begin
			n_fail++;
			$display("unexpected result expected %0d seen %0d", e, o_result);
		end
	endtask : chk_res
	// One request, held over a single taking edge, then a bounded wait
	task automatic run(input fsp_pkg::fsp_op_e op, input logic [20:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge i_clock);
		while (o_ready !== 1'b1 && n < 100)
		begin
			@(negedge i_clock);
			n++;
		end
		i_req = 1;
		i_op = op;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clock);
		i_req = 0;
		while (o_done !== 1'b1 && n < 5000)
		begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 5000)
			chk_byte("done", 8'h01, 8'h00);
	endtask : run
	task automatic rd(input logic [20:0] a, input logic [7:0] e);
		run(fsp_pkg::FSP_OP_READ, a, 8'h00);
		chk_byte("rdata", e, o_rdata);
	endtask : rd
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_prog;
		rd(21'h000100, 8'hff);
		run(fsp_pkg::FSP_OP_PROGRAM, 21'h010020, 8'h5a);
		chk_res(fsp_pkg::FSP_RES_OK);
		rd(21'h010020, 8'h5a);
		run(fsp_pkg::FSP_OP_PROGRAM, 21'h010020, 8'h0f);
		chk_res(fsp_pkg::FSP_RES_OK);
		rd(21'h010020, 8'h0a);
	endtask : t_prog
	task automatic t_tmo;
		tmo = 1;
		run(fsp_pkg::FSP_OP_PROGRAM, 21'h030000, 8'h00);
		tmo = 0;
		chk_res(fsp_pkg::FSP_RES_TIMEOUT);
		chk_byte("sector_bad", 8'h01, {7'h00, o_sector_bad});
		rd(21'h030000, 8'hff); // Device left polling only if reset was sent
	endtask : t_tmo
	task automatic t_prot;
		i_hv_id = 1;
		run(fsp_pkg::FSP_OP_HV_STROBE, 21'h020000, 8'h00);
		i_hv_id = 0;
		run(fsp_pkg::FSP_OP_PROGRAM, 21'h020010, 8'h12);
		rd(21'h020010, 8'hff);
		i_hv_reset = 1;
		run(fsp_pkg::FSP_OP_PROGRAM, 21'h020010, 8'h12);
		i_hv_reset = 0;
		rd(21'h020010, 8'h12);
		run(fsp_pkg::FSP_OP_AUTOSEL, 21'h000000, 8'h00);
		rd(21'h020002, 8'h01);
		rd(21'h020000, ID);
		run(fsp_pkg::FSP_OP_RESET, 21'h000000, 8'hf0);
		i_hv_id = 1;
		// Protect every sector before the chip-wide unprotect
		for (int s = 0; s < 32; s++)
			run(fsp_pkg::FSP_OP_HV_STROBE, 21'(s << 16), 8'h00);
		rd(21'h1f0002, 8'h01);
		run(fsp_pkg::FSP_OP_HV_STROBE, 21'h000040, 8'h00);
		i_hv_id = 0;
		run(fsp_pkg::FSP_OP_AUTOSEL, 21'h000000, 8'h00);
		rd(21'h020002, 8'h00);
		rd(21'h1f0002, 8'h00);
		run(fsp_pkg::FSP_OP_RESET, 21'h000000, 8'hf0);
	endtask : t_prot
	task automatic t_erase;
		logic [7:0] s0;
		run(fsp_pkg::FSP_OP_SECTOR_ERASE, 21'h040000, 8'h00);
		run(fsp_pkg::FSP_OP_ADD_SECTOR, 21'h050000, 8'h00);
		chk_res(fsp_pkg::FSP_RES_OK);
		chk_byte("window", 8'h00, {7'h00, o_rdata[`FSP_BIT_WINDOW]});
		win_hi = 1;
		run(fsp_pkg::FSP_OP_ADD_SECTOR, 21'h060000, 8'h00);
		chk_res(fsp_pkg::FSP_RES_REJECTED);
		win_hi = 0;
		// Erase suspend as a lone command write, then status and array reads
		run(fsp_pkg::FSP_OP_HV_STROBE, 21'h040000, 8'hb0);
		run(fsp_pkg::FSP_OP_READ, 21'h040000, 8'h00);
		s0 = o_rdata;
		chk_byte("suspend_status", 8'h80, s0 & 8'ha0);
		run(fsp_pkg::FSP_OP_READ, 21'h040000, 8'h00);
		chk_byte("suspend_toggles", 8'h04, (s0 ^ o_rdata) & 8'h44);
		rd(21'h010020, 8'h0a);
		run(fsp_pkg::FSP_OP_RESET, 21'h000000, 8'hf0);
		run(fsp_pkg::FSP_OP_CHIP_ERASE, 21'h000000, 8'h00);
		run(fsp_pkg::FSP_OP_RESET, 21'h000000, 8'hf0);
		rd(21'h010020, 8'hff);
		// A lone data write is no command sequence and leaves the array alone
		run(fsp_pkg::FSP_OP_HV_STROBE, 21'h010020, 8'h00);
		rd(21'h010020, 8'hff);
	endtask : t_erase
	// Verdict, reached from the main sequence or the watchdog
	task automatic end_of_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Main sequence after three reset cycles
	initial
	begin
		repeat (3) @(negedge i_clock);
		i_reset_n = 1;
		t_prog();
		t_tmo();
		t_prot();
		t_erase();
		end_of_test();
	end
	// Watchdog, well beyond the expected run
	initial
	begin
		#200000;
		n_fail++;
		end_of_test();
	end
endmodule : test_fsp_host
